// ---- common/pia_pkg.sv ----
// shared constants for the process indicator alarm and function logic
package pia_pkg;
  localparam int CLK_MHZ = 125;
  // display hold/peak message alternation period
  localparam int ALT_TIME_MS = 1;
  localparam int ALT_CYCLES = ALT_TIME_MS * CLK_MHZ * 1000;
  localparam int N_ALARMS = 4;
  localparam logic [15:0] F_ZERO_REF = 16'h0020;  // 32 degrees
  localparam logic [4:0] FILTER_MAX = 5'h14;       // level 20

  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_DIFFREF = 8'h04;
  localparam logic [7:0] OFF_SHIFT   = 8'h08;
  localparam logic [7:0] OFF_COMM    = 8'h0C;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_DISP    = 8'h14;
  localparam logic [7:0] OFF_PEAKS   = 8'h18;
  localparam logic [7:0] OFF_AL_BASE = 8'h20;  // 2 words per alarm
  localparam logic [7:0] OFF_AL_TIME = 8'h40;  // one word per alarm

  // reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_COMM = 32'h0000_0301;

  typedef enum logic [2:0]
  {
    AF_OFF  = 3'h0,
    AF_SENS = 3'h1,
    AF_LO   = 3'h2,
    AF_HI   = 3'h3,
    AF_DLO  = 3'h4,
    AF_DHI  = 3'h5,
    AF_DBND = 3'h6
  } pia_alfunc_type;

  typedef enum logic [2:0]
  {
    ACT_NONE  = 3'h0,
    ACT_HOLD  = 3'h1,
    ACT_RLOFF = 3'h2,
    ACT_CLR   = 3'h3,
    ACT_PEAK  = 3'h4,
    ACT_TARE  = 3'h5
  } pia_action_type;

  typedef enum logic [3:0]
  {
    DM_LIVE = 4'b0001,
    DM_HOLD = 4'b0010,
    DM_PEAK = 4'b0100,
    DM_ERR  = 4'b1000
  } pia_dmode_type;

  // display tag codes
  localparam logic [2:0] TAG_PV   = 3'h0;
  localparam logic [2:0] TAG_HOLD = 3'h1;
  localparam logic [2:0] TAG_PEAK = 3'h2;
  localparam logic [2:0] TAG_ERR  = 3'h3;
endpackage

// ---- hdl/pia_core.sv ----
// process indicator display, alarm and function key logic with ahb-lite registers
//
// What this block does
// - after reset show live process value
// - temperature inputs show absolute value
// - linear inputs arrive pre-scaled between indication limits
// - hold shows frozen value alternating message
// - peak hold shows maximum alternating message
// - fault replaces value with error message
// - differential alarm setpoint locked, shows marker
// - reference writable only if differential alarm; always readable
// - four alarms, seven function codes
// - low/high compare against own setpoint
// - differential uses reference plus deviation
// - hysteresis separates on and off points
// - power-on blocking suppresses existing alarm
// - two alarm times; both zero disables
// - key has six selectable actions
// - digital input has same six actions
// - filter level 0 to 20
// - signed offset; fahrenheit null at 32
// - five selectable baud rates
// - programmable network node number
// - hold toggles per activation
// - peak activation restarts capture
// - memory clear restarts max/min, except when a peak activation fires in the same cycle
// - relay disable toggles; indicators still light
`timescale 1ns/1ps
`default_nettype none
module pia_core
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_value,
  input  wire logic        sample_fault,
  input  wire logic        sample_linear,
  input  wire logic        sample_fahrenheit,
  input  wire logic        function_key,
  input  wire logic        digital_input,
  output logic      [15:0] display_value,
  output logic      [2:0]  display_tag,
  output logic      [3:0]  alarm_relay,
  output logic      [3:0]  alarm_led
);
  import pia_pkg::*;

  // control: [2:0] key action, [5:3] input action, [10:6] filter, [11] fahrenheit null
  logic [31:0] ctrl;
  logic [15:0] diff_ref;
  logic [15:0] value_shift;
  logic [15:0] lin_low;
  logic [15:0] lin_high;
  logic [2:0]  baud_sel;
  logic [7:0]  node_number;
  logic [15:0] setpoint [N_ALARMS];
  logic [15:0] deviation [N_ALARMS];
  logic [2:0]  func_sel [N_ALARMS];
  logic [15:0] hyst [N_ALARMS];
  logic        pwr_block [N_ALARMS];
  logic [7:0]  t1 [N_ALARMS];
  logic [7:0]  t2 [N_ALARMS];

  logic [7:0]  a_addr;
  logic        a_wr;
  logic        any_diff;

  // ahb-lite: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_addr <= 8'h00;
      a_wr <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready)
      begin
        a_addr <= haddr[7:0];
        a_wr <= hsel && htrans[1] && hwrite && (hsize == 3'h2);
      end
    end
  end

  always_comb
  begin
    any_diff = 1'b0;
    for (int i = 0; i < N_ALARMS; i++)
      if (func_sel[i] >= AF_DLO && func_sel[i] <= AF_DBND)
        any_diff = 1'b1;
  end

  // control and per-sample configuration writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= RST_CTRL;
      diff_ref <= 16'h0000;
      value_shift <= 16'h0000;
      lin_low <= 16'h0000;
      lin_high <= 16'h03E8;
      baud_sel <= RST_COMM[2:0];
      node_number <= RST_COMM[15:8];
    end
    else if (a_wr)
    begin
      unique case (a_addr)
        OFF_CTRL:    ctrl <= hwdata;
        OFF_DIFFREF: if (any_diff) diff_ref <= hwdata[15:0];
        OFF_SHIFT:   value_shift <= hwdata[15:0];
        OFF_COMM:
        begin
          if (hwdata[2:0] <= 3'h4)
            baud_sel <= hwdata[2:0];
          node_number <= hwdata[15:8];
          lin_low <= lin_low;
        end
        OFF_PEAKS:
        begin
          lin_low <= hwdata[15:0];
          lin_high <= hwdata[31:16];
        end
        default: ;
      endcase
    end
  end

  // per-alarm configuration: word0 = setpoint|deviation, word1 = func|block|hyst; t1|t2 in the alarm time word
  genvar g;
  generate
    for (g = 0; g < N_ALARMS; g++)
    begin : g_cfg
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          setpoint[g] <= 16'h0000;
          deviation[g] <= 16'h0000;
          func_sel[g] <= AF_OFF;
          pwr_block[g] <= 1'b0;
          hyst[g] <= 16'h0000;
          t1[g] <= 8'h00;
          t2[g] <= 8'h00;
        end
        else if (a_wr && a_addr == OFF_AL_BASE + 8'(g * 8))
        begin
          // differential setpoint locked; deviation locked for others
          if (func_sel[g] < AF_DLO)
            setpoint[g] <= hwdata[15:0];
          else
            deviation[g] <= hwdata[31:16];
        end
        else if (a_wr && a_addr == OFF_AL_BASE + 8'(g * 8 + 4))
        begin
          if (hwdata[2:0] <= AF_DBND)
            func_sel[g] <= hwdata[2:0];
          pwr_block[g] <= hwdata[3];
          hyst[g] <= {4'h0, hwdata[15:4]};
        end
        else if (a_wr && a_addr == OFF_AL_TIME + 8'(g * 4))
        begin
          t1[g] <= hwdata[7:0];
          t2[g] <= hwdata[15:8];
        end
      end
    end
  endgenerate

  // value path: offset, tare, filter, once per sample
  logic [15:0] shifted;
  logic [15:0] tare;
  logic [15:0] pv;
  logic [15:0] peak_hold;
  logic [15:0] maxv;
  logic [15:0] minv;
  logic [15:0] held;
  logic        hold_on;
  logic        relay_off;
  logic        first_done;
  logic        key_q;
  logic        din_q;
  logic        key_ev;
  logic        din_ev;
  logic [2:0]  key_act;
  logic [2:0]  din_act;
  logic [4:0]  filt;

  assign key_act = ctrl[2:0];
  assign din_act = ctrl[5:3];
  assign filt = (ctrl[10:6] > FILTER_MAX) ? FILTER_MAX : ctrl[10:6];
  assign key_ev = function_key && !key_q;
  assign din_ev = digital_input && !din_q;

  function automatic logic fired(input logic [2:0] a, input logic kev, input logic [2:0] ka,
                                 input logic dev, input logic [2:0] da);
    fired = (kev && ka == a) || (dev && da == a);
  endfunction

  always_comb
  begin
    // fahrenheit null reference sits at 32 units
    shifted = sample_value + value_shift - (sample_fahrenheit && ctrl[11] ? F_ZERO_REF : 16'h0000);
  end

  // linear inputs arrive already mapped onto lin_low..lin_high by the front end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pv <= 16'h0000;
      first_done <= 1'b0;
    end
    else if (sample_valid && !sample_fault)
    begin
      first_done <= 1'b1;
      // first-order smoothing, weight 1/(level+1)
      if (filt == 5'h00 || !first_done)
      begin
        pv <= shifted - tare;
      end
      else
      begin
        // 32-bit math so a large reading times level 20 cannot wrap
        pv <= 16'((32'($signed(pv)) * $signed({27'h0000000, filt})
              + 32'($signed(shifted - tare))) / $signed({27'h0000000, filt} + 32'h0000_0001));
      end
    end
  end

  // key and input actions
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      key_q <= 1'b0;
      din_q <= 1'b0;
      hold_on <= 1'b0;
      relay_off <= 1'b0;
      tare <= 16'h0000;
      held <= 16'h0000;
    end
    else
    begin
      key_q <= function_key;
      din_q <= digital_input;
      if (fired(ACT_HOLD, key_ev, key_act, din_ev, din_act))
      begin
        hold_on <= !hold_on;
        held <= pv;
      end
      if (fired(ACT_RLOFF, key_ev, key_act, din_ev, din_act))
        relay_off <= !relay_off;
      if (fired(ACT_TARE, key_ev, key_act, din_ev, din_act) && sample_linear)
        tare <= tare + pv;
    end
  end

  // peak and extremes memory
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      peak_hold <= 16'h8000;
      maxv <= 16'h8000;
      minv <= 16'h7FFF;
    end
    else if (fired(ACT_PEAK, key_ev, key_act, din_ev, din_act))
      peak_hold <= pv;
    else if (fired(ACT_CLR, key_ev, key_act, din_ev, din_act))
    begin
      maxv <= pv;
      minv <= pv;
    end
    else
    begin
      if ($signed(pv) > $signed(peak_hold))
        peak_hold <= pv;
      if ($signed(pv) > $signed(maxv))
        maxv <= pv;
      if ($signed(pv) < $signed(minv))
        minv <= pv;
    end
  end

  // display mode
  pia_dmode_type dmode;
  pia_dmode_type next_dmode;
  logic [$clog2(ALT_CYCLES+1)-1:0] alt_cnt;
  logic alt_phase;

  always_comb
  begin
    if (sample_fault)
      next_dmode = DM_ERR;
    else if (key_act == ACT_PEAK || din_act == ACT_PEAK)
      next_dmode = DM_PEAK;
    else if (hold_on)
      next_dmode = DM_HOLD;
    else
      next_dmode = DM_LIVE;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dmode <= DM_LIVE;
      alt_cnt <= '0;
      alt_phase <= 1'b0;
    end
    else
    begin
      dmode <= next_dmode;
      if (alt_cnt == ($clog2(ALT_CYCLES+1))'(ALT_CYCLES - 1))
      begin
        alt_cnt <= '0;
        alt_phase <= !alt_phase;
      end
      else
        alt_cnt <= alt_cnt + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      display_value <= 16'h0000;
      display_tag <= TAG_PV;
    end
    else
    begin
      unique case (dmode)
        DM_LIVE:
        begin
          display_value <= pv;
          display_tag <= TAG_PV;
        end
        DM_HOLD:
        begin
          display_value <= held;
          display_tag <= alt_phase ? TAG_HOLD : TAG_PV;
        end
        DM_PEAK:
        begin
          display_value <= peak_hold;
          display_tag <= alt_phase ? TAG_PEAK : TAG_PV;
        end
        DM_ERR:
        begin
          display_value <= 16'h0000;
          display_tag <= TAG_ERR;
        end
        default:
        begin
          display_value <= pv;
          display_tag <= TAG_PV;
        end
      endcase
    end
  end

  // alarms: t1 = delay before on (samples), t2 = on duration (samples), 0 = untimed
  logic [3:0] cond;
  logic [3:0] active;
  logic [3:0] blocked;
  logic [7:0] tcnt [N_ALARMS];
  logic       sample_seen;

  // pv takes the sample one edge after the strobe; alarms judge it an edge later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sample_seen <= 1'b0;
    else
      sample_seen <= sample_valid;
  end

  generate
    for (g = 0; g < N_ALARMS; g++)
    begin : g_al
      logic signed [16:0] thr;
      logic signed [16:0] hy;
      logic signed [16:0] v;
      logic signed [16:0] dv;
      logic raw;

      always_comb
      begin
        v = 17'($signed(pv));
        hy = 17'($signed(hyst[g]));
        dv = 17'($signed(deviation[g]));
        thr = 17'($signed(setpoint[g]));
        raw = 1'b0;
        if (func_sel[g] >= AF_DLO)
          thr = 17'($signed(diff_ref)) + dv;
        unique case (func_sel[g])
          AF_SENS: raw = sample_fault;
          AF_LO, AF_DLO:
            raw = active[g] ? (v < thr + hy) : (v < thr);
          AF_HI, AF_DHI:
            raw = active[g] ? (v > thr - hy) : (v > thr);
          AF_DBND:
            raw = active[g]
              ? (v > 17'($signed(diff_ref)) + dv - hy || v < 17'($signed(diff_ref)) - dv + hy)
              : (v > 17'($signed(diff_ref)) + dv || v < 17'($signed(diff_ref)) - dv);
          default: raw = 1'b0;
        endcase
        cond[g] = raw;
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          active[g] <= 1'b0;
          blocked[g] <= 1'b1;
          tcnt[g] <= 8'h00;
        end
        else if (sample_seen)
        begin
          // blocking lifts once the condition first clears, or at the first sample when pwr_block is off
          if (!cond[g] || !pwr_block[g])
            blocked[g] <= 1'b0;
          if (!cond[g])
          begin
            active[g] <= 1'b0;
            tcnt[g] <= 8'h00;
          end
          else if (t1[g] == 8'h00 && t2[g] == 8'h00)
            active[g] <= 1'b1;
          else if (tcnt[g] != 8'hFF)
          begin
            tcnt[g] <= tcnt[g] + 8'h01;
            active[g] <= (tcnt[g] >= t1[g])
              && (t2[g] == 8'h00 || 9'(tcnt[g]) < 9'(t1[g]) + 9'(t2[g]));
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      alarm_relay <= 4'h0;
      alarm_led <= 4'h0;
    end
    else
    begin
      alarm_led <= active & ~blocked;
      alarm_relay <= relay_off ? 4'h0 : (active & ~blocked);
    end
  end

  // read mux
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      hrdata <= 32'h0000_0000;
      case (haddr[7:0])
        OFF_CTRL:    hrdata <= ctrl;
        OFF_DIFFREF: hrdata <= {15'h0000, any_diff, diff_ref};
        OFF_SHIFT:   hrdata <= {16'h0000, value_shift};
        OFF_COMM:    hrdata <= {16'h0000, node_number, 5'h00, baud_sel};
        OFF_STATUS:  hrdata <= {22'h000000, relay_off, hold_on, active & ~blocked, blocked};
        OFF_DISP:    hrdata <= {13'h0000, display_tag, display_value};
        OFF_PEAKS:   hrdata <= {maxv, minv};
        default:
        begin
          for (int i = 0; i < N_ALARMS; i++)
          begin
            if (haddr[7:0] == OFF_AL_BASE + 8'(i * 8))
              hrdata <= {deviation[i], setpoint[i]};
            if (haddr[7:0] == OFF_AL_BASE + 8'(i * 8 + 4))
              hrdata <= {16'h0000, hyst[i][11:0], pwr_block[i], func_sel[i]};
            if (haddr[7:0] == OFF_AL_TIME + 8'(i * 4))
              hrdata <= {16'h0000, t2[i], t1[i]};
          end
        end
      endcase
    end
  end

  relay_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
    relay_off |=> alarm_relay == 4'h0) else $error("relay on while disabled");
  led_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> alarm_led == $past(active & ~blocked)) else $error("led mismatch");
  err_disp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_fault ##2 sample_fault |-> display_tag == TAG_ERR) else $error("no error tag");
  hold_tog_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fired(ACT_HOLD, key_ev, key_act, din_ev, din_act) |=> hold_on != $past(hold_on))
    else $error("hold no toggle");
  peak_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fired(ACT_PEAK, key_ev, key_act, din_ev, din_act) |=> peak_hold == $past(pv))
    else $error("peak not restarted");
  clr_mem_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fired(ACT_CLR, key_ev, key_act, din_ev, din_act) && !fired(ACT_PEAK, key_ev, key_act, din_ev, din_act)
    |=> maxv == $past(pv) && minv == $past(pv)) else $error("extremes not cleared");
  sens_al_a: assert property (@(posedge hclk) disable iff (!hresetn)
    func_sel[3] == AF_SENS && sample_fault |-> cond[3]) else $error("sensor alarm missing");
  ref_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !any_diff |=> diff_ref == $past(diff_ref)) else $error("reference written");
endmodule
`default_nettype wire

// ---- bench/pia_panel.sv ----
// front panel function key and digital input contact model
`timescale 1ns/1ps
`default_nettype none
module pia_panel
#(
  parameter int PRESS_CYC = 4
)
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic key_tap,
  input  wire logic din_tap,
  output logic      function_key,
  output logic      digital_input
);
  int key_cnt;
  int din_cnt;

  // a tap is one whole press and release, so each one is a single activation
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      key_cnt <= 0;
    else if (key_tap)
      key_cnt <= PRESS_CYC;
    else if (key_cnt != 0)
      key_cnt <= key_cnt - 1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      din_cnt <= 0;
    else if (din_tap)
      din_cnt <= PRESS_CYC;
    else if (din_cnt != 0)
      din_cnt <= din_cnt - 1;
  end

  // released contact reads open, never the last level
  assign function_key  = (key_cnt != 0);
  assign digital_input = (din_cnt != 0);
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the process indicator core
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pia_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sample_valid = 1'b0;
  logic [15:0] sample_value = 16'h0000;
  logic        sample_fault = 1'b0;
  logic        sample_linear = 1'b0;
  logic        sample_fahrenheit = 1'b0;
  logic        function_key;
  logic        digital_input;
  logic        key_tap = 1'b0;
  logic        din_tap = 1'b0;
  logic [15:0] display_value;
  logic [2:0]  display_tag;
  logic [3:0]  alarm_relay;
  logic [3:0]  alarm_led;
  logic [31:0] r;
  int          err_count = 0;
  int          num_checks = 0;

  always #4 hclk = ~hclk;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  pia_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
    .sample_value(sample_value), .sample_fault(sample_fault), .sample_linear(sample_linear),
    .sample_fahrenheit(sample_fahrenheit), .function_key(function_key),
    .digital_input(digital_input), .display_value(display_value),
    .display_tag(display_tag), .alarm_relay(alarm_relay), .alarm_led(alarm_led));

  pia_panel i_panel (.hclk(hclk), .hresetn(hresetn), .key_tap(key_tap), .din_tap(din_tap),
    .function_key(function_key), .digital_input(digital_input));

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      err_count++;
      summarize();
    end
  endtask

  // one whole-word transfer; read data is taken at the data phase's ready edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask

  task automatic smp(input logic [15:0] v, input logic f);
    sample_valid <= 1'b1;
    sample_value <= v;
    sample_fault <= f;
    @(posedge hclk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  task automatic tap(input logic k);
    key_tap <= k;
    din_tap <= !k;
    @(posedge hclk);
    key_tap <= 1'b0;
    din_tap <= 1'b0;
    repeat (12) @(posedge hclk);
  endtask

  task automatic t_reset();
    chk({31'h0, hreadyout}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    rdchk(OFF_CTRL, RST_CTRL);
    rdchk(OFF_COMM, RST_COMM);
    wr(8'h80, 32'hFFFF_FFFF);
    rdchk(8'h80, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_disp();
    smp(16'h0064, 1'b0);
    chk({16'h0, display_value}, 32'h64);
    chk({29'h0, display_tag}, {29'h0, TAG_PV});
    wr(OFF_SHIFT, 32'h0000_0005);
    smp(16'h0064, 1'b0);
    chk({16'h0, display_value}, 32'h69);
    wr(OFF_SHIFT, 32'h0000_0000);
    $display("test display done");
  endtask

  task automatic t_alarm();
    wr(8'h20, 32'h0005_00C8);
    rdchk(8'h20, 32'h0000_00C8);
    wr(8'h24, 32'h0000_00A3);
    smp(16'h00FA, 1'b0);
    chk({28'h0, alarm_led}, 32'h1);
    chk({28'h0, alarm_relay}, 32'h1);
    smp(16'h0096, 1'b0);
    chk({28'h0, alarm_led}, 32'h0);
    $display("test alarm done");
  endtask

  task automatic t_diff();
    wr(8'h2C, 32'h0000_0005);
    rdchk(OFF_DIFFREF, 32'h0001_0000);
    wr(OFF_DIFFREF, 32'h0000_0064);
    wr(8'h28, 32'h0014_0033);
    rdchk(8'h28, 32'h0014_0000);
    smp(16'h0082, 1'b0);
    chk({28'h0, alarm_led}, 32'h2);
    for (int c = 0; c < 7; c++)
    begin
      wr(8'h34, c);
      rdchk(8'h34, c);
    end
    wr(8'h34, 32'h0000_0007);
    rdchk(8'h34, 32'h0000_0006);
    wr(8'h34, 32'h0000_0000);
    $display("test differential done");
  endtask

  task automatic t_keys();
    wr(OFF_CTRL, 32'h0000_0011);
    tap(1'b0);
    chk({28'h0, alarm_relay}, 32'h0);
    chk({28'h0, alarm_led}, 32'h2);
    tap(1'b0);
    chk({28'h0, alarm_relay}, 32'h2);
    tap(1'b1);
    xfer(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(r & 32'h100, 32'h100);
    smp(16'h008C, 1'b0);
    chk({16'h0, display_value}, 32'h82);
    tap(1'b1);
    smp(16'h008C, 1'b0);
    chk({16'h0, display_value}, 32'h8C);
    for (int a = 0; a < 6; a++)
    begin
      wr(OFF_CTRL, a * 9);
      rdchk(OFF_CTRL, a * 9);
    end
    wr(OFF_CTRL, 32'h0000_0000);
    $display("test keys done");
  endtask

  task automatic t_fault();
    wr(8'h3C, 32'h0000_0001);
    smp(16'h0082, 1'b1);
    chk({29'h0, display_tag}, {29'h0, TAG_ERR});
    chk({31'h0, alarm_led[3]}, 32'h1);
    smp(16'h0082, 1'b0);
    $display("test fault done");
  endtask

  task automatic t_peak();
    wr(OFF_CTRL, 32'h0000_0004);
    tap(1'b1);
    chk({16'h0, display_value}, 32'h82);
    smp(16'h0090, 1'b0);
    smp(16'h0070, 1'b0);
    chk({16'h0, display_value}, 32'h90);
    tap(1'b1);
    chk({16'h0, display_value}, 32'h70);
    wr(OFF_CTRL, 32'h0000_0003);
    tap(1'b1);
    rdchk(OFF_PEAKS, 32'h0070_0070);
    smp(16'h0075, 1'b0);
    rdchk(OFF_PEAKS, 32'h0075_0070);
    wr(OFF_CTRL, 32'h0000_0040);
    smp(16'h0085, 1'b0);
    chk({16'h0, display_value}, 32'h7D);
    wr(OFF_CTRL, 32'h0000_0000);
    $display("test peak done");
  endtask

  task automatic t_comm();
    wr(OFF_COMM, 32'h0000_2A04);
    rdchk(OFF_COMM, 32'h0000_2A04);
    wr(OFF_COMM, 32'h0000_2A05);
    rdchk(OFF_COMM, 32'h0000_2A04);
    $display("test comm done");
  endtask

  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_disp();
    t_alarm();
    t_diff();
    t_keys();
    t_fault();
    t_comm();
    t_peak();
    summarize();
  end
endmodule
`default_nettype wire
